// *** usb_evt_pkg.sv ***
// constants and carrier types for the usb device event and interrupt block
// assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus
package usb_evt_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_PKT_READY = 8'h00;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] OFS_DEV_STATE = 8'h0c;
  localparam logic [7:0] OFS_SYS_CTRL = 8'h10;
  localparam logic [7:0] OFS_POLARITY = 8'h14;
  // packet ready field layout
  localparam int RX_EPS = 3;
  localparam int TX_EPS = 4;
  localparam int TX_RDY_LSB = 4;
  localparam int RX_INT_BIT [RX_EPS] = '{3, 1, 2};
  localparam int TX_INT_BIT [TX_EPS] = '{4, 1, 2, 7};
  // interrupt and control bits
  localparam int INT_BUS_RESET = 5;
  localparam int INT_SUSPEND = 6;
  localparam int DEV_CLR_BUS_RESET = 5;
  localparam int DEV_SUSPENDED = 6;
  localparam int SYS_SOFT_RESET = 0;
  localparam int POL_HIGH_BIT = 0;
  localparam logic [3:0] OSC_STOP_CODE = 4'ha;
  // reset values
  localparam logic [7:0] PKT_READY_RESET = 8'h00;
  localparam logic [7:0] INT_ENABLE_RESET = 8'h01;
  localparam logic [7:0] INT_STATUS_RESET = 8'h00;
  localparam logic POLARITY_RESET = 1'b0;
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam real BUS_RESET_US = 2.5;
  localparam int SUSPEND_MS = 3;
  localparam int BUS_RESET_CYC = int'($ceil(BUS_RESET_US * 1000.0 / CLK_PERIOD_NS));
  localparam int SUSPEND_CYC = SUSPEND_MS * 1000000 / CLK_PERIOD_NS;

  typedef struct packed
  {
    logic dp;
    logic dm;
  } line_t;

  typedef struct packed
  {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_req_t;
endpackage : usb_evt_pkg

// *** usb_device_event_interrupts.sv ***
// usb device event flags, interrupt status and request, bus reset and
// suspend detection, software reset and oscillator stop control
// assumes an AHB-Lite master on hclk, usb line pins from the bus side,
// and receive/transmit events from fifo logic on the same clock
//
// Overview of operation
// - good received packet sets its ready bit
// - enabled receive ready also sets status, raises request
// - mcu writes one, ready and status clear
// - end of packet marks received packet end
// - receive ready bits 0,1,2 map to 3,1,2
// - transmit fifo ready clears transmit ready bit
// - enabled transmit ready clear sets status bit
// - mcu writes one, ready set, status cleared
// - ready set early sends a short packet
// - transmit bits 4..7 map to 4,1,2,7
// - se0 held 2.5 us means bus reset
// - enabled bus reset sets status bit 5
// - device state bit 5 write clears status
// - idle bus for 3 ms means suspend
// - enabled suspend sets status bit 6
// - resume or bus reset clears suspend status
// - reset pin low resets whole block
// - system control bit 0 does same reset, except the line syncs and the bus side
// - either reset restarts a stopped oscillator
// - disabled status bits read as zero
// - after reset only setup interrupt enabled
// - polarity bit picks request level, low default
`timescale 1ns/1ps
module usb_device_event_interrupts
  import usb_evt_pkg::*;
#(
  parameter int SUSPEND_CYCLES = SUSPEND_CYC
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic usb_dp,
  input wire logic usb_dm,
  input wire logic rx_eop,
  input wire logic [1:0] rx_ep,
  input wire logic rx_ok,
  input wire logic [3:0] tx_fifo_ready,
  output logic irq_out,
  output logic osc_stop,
  output logic suspended
);

  localparam int IW = $clog2(SUSPEND_CYCLES + 1);
  localparam int RW = $clog2(BUS_RESET_CYC + 1);

  if (SUSPEND_CYCLES <= BUS_RESET_CYC)
  begin : g_bad_suspend
    $error("suspend count must exceed bus reset count");
  end

  line_t sync1_reg, sync2_reg;
  logic [RW-1:0] se0_cnt_reg, se0_cnt_next;
  logic [IW-1:0] idle_cnt_reg, idle_cnt_next;
  logic suspend_reg, suspend_next;
  logic [7:0] pkt_reg, pkt_next;
  logic [7:0] en_reg, en_next;
  logic [7:0] stat_reg, stat_next;
  logic pol_reg, pol_next;
  logic osc_reg, osc_next;
  logic soft_rst_reg, soft_rst_next;
  logic irq_reg, irq_next;
  ahb_req_t req_reg, req_next;
  logic ready_reg, ready_next;
  logic [31:0] rdata_reg;
  logic [7:0] int_set, int_clr;
  logic [RX_EPS-1:0] rx_set, rx_clr;
  logic [TX_EPS-1:0] tx_drop, tx_setw;

  // line state decode, only from the second sync stage
  wire line_se0 = !sync2_reg.dp && !sync2_reg.dm;
  wire line_j = sync2_reg.dp && !sync2_reg.dm;
  wire line_k = !sync2_reg.dp && sync2_reg.dm;

  wire bus_reset_hit = line_se0 && (se0_cnt_reg == RW'(BUS_RESET_CYC - 1));
  wire suspend_hit = line_j && (idle_cnt_reg == IW'(SUSPEND_CYCLES - 1));
  wire resume_hit = suspend_reg && line_k;

  // bus decode
  wire ahb_take = hsel && htrans[1] && hready;
  wire wr_now = req_reg.valid && req_reg.write;
  wire rd_now = req_reg.valid && !req_reg.write;
  wire wr_pkt = wr_now && (req_reg.addr == OFS_PKT_READY);
  wire wr_en = wr_now && (req_reg.addr == OFS_INT_ENABLE);
  wire wr_dev = wr_now && (req_reg.addr == OFS_DEV_STATE);
  wire wr_sys = wr_now && (req_reg.addr == OFS_SYS_CTRL);
  wire wr_pol = wr_now && (req_reg.addr == OFS_POLARITY);
  wire [7:0] wbyte = hwdata[7:0];
  wire [7:0] stat_vis = stat_reg & en_reg;
  wire [7:0] dev_vis = 8'(suspend_reg) << DEV_SUSPENDED |
                       8'(stat_vis[INT_BUS_RESET]) << DEV_CLR_BUS_RESET;
  wire [7:0] sys_vis = {osc_reg ? OSC_STOP_CODE : 4'h0, 4'h0};
  wire [7:0] rd_byte =
    (req_reg.addr == OFS_PKT_READY) ? pkt_reg :
    (req_reg.addr == OFS_INT_ENABLE) ? en_reg :
    (req_reg.addr == OFS_INT_STATUS) ? stat_vis :
    (req_reg.addr == OFS_DEV_STATE) ? dev_vis :
    (req_reg.addr == OFS_SYS_CTRL) ? sys_vis :
    (req_reg.addr == OFS_POLARITY) ? {7'h00, pol_reg} : 8'h00;

  // only word accesses are expected; hsize is not checked and haddr[7:0] must equal an offset exactly
  assign req_next = ahb_take ? ahb_req_t'{valid: 1'b1, write: hwrite, addr: haddr[7:0]}
                             : ahb_req_t'{valid: 1'b0, write: 1'b0, addr: 8'h00};
  // reads take one wait state so a write just before is always seen
  assign ready_next = !(ahb_take && !hwrite);

  // counters run only while the line stays in one state
  assign se0_cnt_next = !line_se0 ? '0 :
                        (se0_cnt_reg == RW'(BUS_RESET_CYC)) ? se0_cnt_reg : se0_cnt_reg + 1'b1;
  assign idle_cnt_next = !line_j ? '0 :
                         (idle_cnt_reg == IW'(SUSPEND_CYCLES)) ? idle_cnt_reg
                                                               : idle_cnt_reg + 1'b1;
  assign suspend_next = (suspend_reg || suspend_hit) && !(resume_hit || bus_reset_hit);

  // rx_eop is the end of every received packet, full size or short
  genvar g;
  for (g = 0; g < RX_EPS; g++)
  begin : g_rx
    assign rx_set[g] = rx_eop && rx_ok && (rx_ep == 2'(g));
    assign rx_clr[g] = wr_pkt && wbyte[g];
    assign pkt_next[g] = rx_set[g] || (pkt_reg[g] && !rx_clr[g]);
  end
  assign pkt_next[RX_EPS] = 1'b0;
  for (g = 0; g < TX_EPS; g++)
  begin : g_tx
    assign tx_drop[g] = tx_fifo_ready[g] && pkt_reg[TX_RDY_LSB + g];
    // the fifo sends whatever it holds once this bit is set, short or not
    assign tx_setw[g] = wr_pkt && wbyte[TX_RDY_LSB + g];
    // a fifo event in the same cycle as the write wins
    assign pkt_next[TX_RDY_LSB + g] = !tx_drop[g] &&
                                      (pkt_reg[TX_RDY_LSB + g] || tx_setw[g]);
  end

  always_comb
  begin
    int_set = '0;
    int_clr = '0;
    for (int i = 0; i < RX_EPS; i++)
    begin
      int_set[RX_INT_BIT[i]] = int_set[RX_INT_BIT[i]] | rx_set[i];
      int_clr[RX_INT_BIT[i]] = int_clr[RX_INT_BIT[i]] | rx_clr[i];
    end
    for (int i = 0; i < TX_EPS; i++)
    begin
      int_set[TX_INT_BIT[i]] = int_set[TX_INT_BIT[i]] | tx_drop[i];
      int_clr[TX_INT_BIT[i]] = int_clr[TX_INT_BIT[i]] | tx_setw[i];
    end
    int_set[INT_BUS_RESET] = bus_reset_hit;
    int_clr[INT_BUS_RESET] = wr_dev && wbyte[DEV_CLR_BUS_RESET];
    int_set[INT_SUSPEND] = suspend_hit;
    int_clr[INT_SUSPEND] = resume_hit || bus_reset_hit;
  end

  // set wins over clear; status only latches while enabled
  assign stat_next = (int_set & en_reg) | (stat_reg & ~int_clr);
  assign en_next = wr_en ? wbyte : en_reg;
  assign pol_next = wr_pol ? wbyte[POL_HIGH_BIT] : pol_reg;
  assign osc_next = osc_reg || (wr_sys && (wbyte[7:4] == OSC_STOP_CODE));
  assign soft_rst_next = wr_sys && wbyte[SYS_SOFT_RESET];
  // request built from next values so it moves in the same cycle as status
  assign irq_next = pol_next ? |(stat_next & en_next) : !(|(stat_next & en_next));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      req_reg <= '0;
      ready_reg <= 1'b1;
      rdata_reg <= '0;
    end
    else if (ce)
    begin
      sync1_reg <= '{dp: usb_dp, dm: usb_dm};
      sync2_reg <= sync1_reg;
      req_reg <= req_next;
      ready_reg <= ready_next;
      if (rd_now)
      begin
        rdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  // the software reset clears the same state as the pin except the line syncs; the bus side is
  // left alone so the write that asked for it completes cleanly
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      se0_cnt_reg <= '0;
      idle_cnt_reg <= '0;
      suspend_reg <= 1'b0;
      pkt_reg <= PKT_READY_RESET;
      en_reg <= INT_ENABLE_RESET;
      stat_reg <= INT_STATUS_RESET;
      pol_reg <= POLARITY_RESET;
      osc_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      irq_reg <= 1'b1;
    end
    else if (ce && soft_rst_reg)
    begin
      se0_cnt_reg <= '0;
      idle_cnt_reg <= '0;
      suspend_reg <= 1'b0;
      pkt_reg <= PKT_READY_RESET;
      en_reg <= INT_ENABLE_RESET;
      stat_reg <= INT_STATUS_RESET;
      pol_reg <= POLARITY_RESET;
      osc_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      irq_reg <= 1'b1;
    end
    else if (ce)
    begin
      se0_cnt_reg <= se0_cnt_next;
      idle_cnt_reg <= idle_cnt_next;
      suspend_reg <= suspend_next;
      pkt_reg <= pkt_next;
      en_reg <= en_next;
      stat_reg <= stat_next;
      pol_reg <= pol_next;
      osc_reg <= osc_next;
      soft_rst_reg <= soft_rst_next;
      irq_reg <= irq_next;
    end
  end

  assign hrdata = rdata_reg;
  assign hreadyout = ready_reg;
  assign hresp = 1'b0;
  assign irq_out = irq_reg;
  // the clock source must not be stopped while suspended: resume goes unseen; osc_stop follows osc_reg whether suspended or not
  assign osc_stop = osc_reg;
  assign suspended = suspend_reg;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  wire live = ce && !soft_rst_reg;

  sequence s_suspend_enter;
    live && suspend_hit && en_reg[INT_SUSPEND];
  endsequence

  sequence s_suspend_held;
    stat_reg[INT_SUSPEND] && suspend_reg;
  endsequence

  a_rx_ready_set: assert property (
    live && rx_eop && rx_ok && rx_ep == 2'd0 |=> pkt_reg[0])
    else $error("receive ready bit not set");

  a_rx_int_map: assert property (
    live && rx_set[0] && en_reg[3] && !wr_en |=> stat_reg[3] && irq_out == pol_reg)
    else $error("endpoint 0 receive status not on bit 3");

  a_rx_ack_clear: assert property (
    live && wr_pkt && hwdata[0] && !rx_set[0] |=> !pkt_reg[0] && !stat_reg[3])
    else $error("receive acknowledge did not clear");

  a_tx_int_map: assert property (
    live && tx_drop[1] && en_reg[1] |=> stat_reg[1] && !pkt_reg[5])
    else $error("endpoint 1 transmit event not on bit 1");

  a_tx_ack_set: assert property (
    live && wr_pkt && hwdata[4] && !tx_fifo_ready[0] |=> pkt_reg[4] && !stat_reg[4])
    else $error("transmit ready write failed");

  a_bus_reset_int: assert property (
    live && bus_reset_hit && en_reg[INT_BUS_RESET] |=> stat_reg[INT_BUS_RESET]
      && $past(se0_cnt_reg) == RW'(BUS_RESET_CYC - 1))
    else $error("bus reset status not raised");

  a_bus_reset_clear: assert property (
    live && wr_dev && hwdata[DEV_CLR_BUS_RESET] && !bus_reset_hit
      |=> !stat_reg[INT_BUS_RESET])
    else $error("bus reset status not cleared");

  a_suspend_int: assert property (
    s_suspend_enter |=> s_suspend_held)
    else $error("suspend status not raised");

  a_resume_clear: assert property (
    live && resume_hit |=> !stat_reg[INT_SUSPEND] && !suspend_reg)
    else $error("resume did not clear suspend");

  a_irq_level_match: assert property (
    ##1 irq_out == (pol_reg ? |(stat_reg & en_reg) : !(|(stat_reg & en_reg))))
    else $error("request level wrong");

  a_soft_reset_all: assert property (
    ce && soft_rst_reg |=> en_reg == INT_ENABLE_RESET && !osc_stop && !pol_reg
      && stat_reg == INT_STATUS_RESET)
    else $error("software reset incomplete");

  a_status_masked: assert property (
    ce && rd_now && req_reg.addr == OFS_INT_STATUS
      |=> hrdata[7:0] == $past(stat_reg & en_reg))
    else $error("disabled status read nonzero");

  // per endpoint, line and reset checks
  a_rx_ep1_map: assert property (
    live && rx_set[1] && en_reg[1] |=> stat_reg[1] && pkt_reg[1])
    else $error("endpoint 1 receive status not on bit 1");

  a_rx_ep2_map: assert property (
    live && rx_set[2] && en_reg[2] |=> stat_reg[2] && pkt_reg[2])
    else $error("endpoint 2 receive status not on bit 2");

  a_rx_masked: assert property (
    live && rx_set[0] && !en_reg[3] && !stat_reg[3] |=> !stat_reg[3])
    else $error("disabled receive status latched");

  a_tx_ready_drop: assert property (
    live && tx_drop[0] |=> !pkt_reg[4])
    else $error("transmit ready bit not cleared");

  a_tx_status_edge: assert property (
    live && tx_drop[0] && en_reg[4] |=> stat_reg[4])
    else $error("transmit status not set on clear");

  a_tx_ep3_map: assert property (
    live && tx_drop[3] && en_reg[7] |=> stat_reg[7] && !pkt_reg[7])
    else $error("endpoint 3 transmit event not on bit 7");

  a_bus_reset_line: assert property (
    live && bus_reset_hit |-> $past(line_se0, 24))
    else $error("bus reset without held se0");

  a_reset_ends_suspend: assert property (
    live && bus_reset_hit |=> !suspend_reg && !stat_reg[INT_SUSPEND])
    else $error("bus reset left suspend set");

  a_suspend_enter: assert property (
    live && suspend_hit |=> suspend_reg)
    else $error("idle bus did not suspend");

  a_soft_reset_arm: assert property (
    live && wr_sys && hwdata[SYS_SOFT_RESET] |=> soft_rst_reg)
    else $error("software reset not armed");

  a_osc_restart: assert property (
    ce && soft_rst_reg && osc_reg |=> !osc_stop)
    else $error("oscillator not restarted");

  a_pol_write: assert property (
    live && wr_pol |=> pol_reg == $past(hwdata[POL_HIGH_BIT]))
    else $error("polarity bit not written");

endmodule : usb_device_event_interrupts

// *** usb_line_model.sv ***
// host side of the usb cable: drives d+/d- to the state the bench picks
// assumes full speed signalling; the bench changes the state just after a clock edge
`timescale 1ns/1ps
module usb_line_model
(
  input wire logic [1:0] line_sel,
  output logic usb_dp,
  output logic usb_dm
);
  // 0 = J idle, 1 or 3 = se0, 2 = K; a held se0 is a bus reset
  // pins are driven at every moment, so no stale level is left on them
  assign usb_dp = (line_sel == 2'd0);
  assign usb_dm = (line_sel == 2'd2);
endmodule : usb_line_model

// *** usb_device_event_interrupts_tb.sv ***
// self-checking bench for the usb event and interrupt block
// assumes one 10 MHz clock, hready looped back from hreadyout, short suspend count
`timescale 1ns/1ps
module usb_device_event_interrupts_tb;
  import usb_evt_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic ce = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic rx_eop = 1'b0;
  logic [1:0] rx_ep = 2'd0;
  logic rx_ok = 1'b0;
  logic [3:0] tx_fifo_ready = 4'h0;
  // start in K so the bus does not look idle until the suspend test
  logic [1:0] line_sel = 2'd2;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [7:0] m;
  logic hreadyout, hresp, irq_out, osc_stop, suspended, usb_dp, usb_dm;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  int ep;

  initial
  begin
    forever #50 hclk = ~hclk;
  end

  // suspend count shortened; it must stay above the bus reset count
  usb_device_event_interrupts #(.SUSPEND_CYCLES(40)) DUT
  (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .usb_dp(usb_dp), .usb_dm(usb_dm), .rx_eop(rx_eop), .rx_ep(rx_ep), .rx_ok(rx_ok),
    .tx_fifo_ready(tx_fifo_ready), .irq_out(irq_out), .osc_stop(osc_stop),
    .suspended(suspended)
  );

  usb_line_model host_line
  (
    .line_sel(line_sel), .usb_dp(usb_dp), .usb_dm(usb_dm)
  );

  function automatic int rx_bit(input int e);
    return (e == 0) ? 3 : e;
  endfunction : rx_bit

  function automatic int tx_bit(input int e);
    return (e == 0) ? 4 : ((e == 3) ? 7 : e);
  endfunction : tx_bit

  task automatic finish_test();
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one single transfer; waits on hready, never on a fixed cycle count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk);
    while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk);
    while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  // order: hresp (always okay), irq_out, osc_stop, suspended; read mid-cycle
  task automatic pins_chk(input logic [2:0] exp);
    @(negedge hclk);
    chk({28'h0, hresp, irq_out, osc_stop, suspended}, {29'h0, exp});
  endtask : pins_chk

  task automatic rx_pkt(input int e, input logic ok);
    @(posedge hclk);
    rx_eop <= 1'b1;
    rx_ok <= ok;
    rx_ep <= e[1:0];
    @(posedge hclk);
    rx_eop <= 1'b0;
    rx_ok <= 1'b0;
  endtask : rx_pkt

  task automatic tx_rdy(input int e);
    @(posedge hclk);
    tx_fifo_ready <= 4'h1 << e;
    @(posedge hclk);
    tx_fifo_ready <= 4'h0;
  endtask : tx_rdy

  task automatic line_hold(input logic [1:0] s, input int n);
    @(posedge hclk);
    line_sel <= s;
    repeat (n) @(posedge hclk);
  endtask : line_hold

  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  initial
  begin
    void'($urandom(32'h9398b677));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    pins_chk(3'b100);
    rd_chk(OFS_INT_ENABLE, 32'h01);
    rd_chk(OFS_POLARITY, 32'h0);
    rx_pkt(1, 1'b0);
    rd_chk(OFS_PKT_READY, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      m = 8'($urandom);
      ep = $urandom_range(2);
      xfer(1'b1, OFS_INT_ENABLE, {24'h0, m});
      rx_pkt(ep, 1'b1);
      rd_chk(OFS_PKT_READY, 32'h1 << ep);
      rd_chk(OFS_INT_STATUS, {24'h0, m & (8'h1 << rx_bit(ep))});
      pins_chk({~m[rx_bit(ep)], 2'b00});
      xfer(1'b1, OFS_PKT_READY, 32'h1 << ep);
      rd_chk(OFS_PKT_READY, 32'h0);
      pins_chk(3'b100);
    end
    // ce low freezes the block, so a packet seen then is lost
    @(posedge hclk);
    ce <= 1'b0;
    rx_pkt(2, 1'b1);
    @(posedge hclk);
    ce <= 1'b1;
    rd_chk(OFS_PKT_READY, 32'h0);
    xfer(1'b1, OFS_INT_ENABLE, 32'hff);
    // m tracks transmit ready bits left set by earlier endpoints
    m = 8'h00;
    for (int e = 0; e < 4; e++)
    begin
      xfer(1'b1, OFS_PKT_READY, 32'h10 << e);
      rd_chk(OFS_PKT_READY, {24'h0, m | (8'h10 << e)});
      tx_rdy(e);
      rd_chk(OFS_PKT_READY, {24'h0, m});
      rd_chk(OFS_INT_STATUS, 32'h1 << tx_bit(e));
      pins_chk(3'b000);
      xfer(1'b1, OFS_PKT_READY, 32'h10 << e);
      m = m | (8'h10 << e);
      rd_chk(OFS_INT_STATUS, 32'h0);
      pins_chk(3'b100);
    end
    // se0 just short of the reset time must be ignored
    line_hold(2'd1, 23);
    line_hold(2'd2, 4);
    rd_chk(OFS_INT_STATUS, 32'h0);
    line_hold(2'd1, 35);
    line_hold(2'd2, 4);
    rd_chk(OFS_INT_STATUS, 32'h20);
    rd_chk(OFS_DEV_STATE, 32'h20);
    xfer(1'b1, OFS_DEV_STATE, 32'h20);
    rd_chk(OFS_INT_STATUS, 32'h0);
    pins_chk(3'b100);
    line_hold(2'd0, 60);
    pins_chk(3'b001);
    rd_chk(OFS_INT_STATUS, 32'h40);
    rd_chk(OFS_DEV_STATE, 32'h40);
    line_hold(2'd2, 5);
    pins_chk(3'b100);
    line_hold(2'd0, 60);
    line_hold(2'd1, 35);
    line_hold(2'd2, 4);
    pins_chk(3'b000);
    rd_chk(OFS_INT_STATUS, 32'h20);
    xfer(1'b1, OFS_DEV_STATE, 32'h20);
    xfer(1'b1, OFS_POLARITY, 32'h1);
    pins_chk(3'b000);
    rx_pkt(0, 1'b1);
    pins_chk(3'b100);
    // the oscillator is stopped here while the bus is active; the block does not prevent a stop in suspend
    xfer(1'b1, OFS_SYS_CTRL, 32'ha0);
    pins_chk(3'b110);
    rd_chk(OFS_SYS_CTRL, 32'ha0);
    xfer(1'b1, OFS_SYS_CTRL, 32'h01);
    @(posedge hclk);
    pins_chk(3'b100);
    rd_chk(OFS_INT_ENABLE, 32'h01);
    rd_chk(OFS_PKT_READY, 32'h0);
    xfer(1'b1, OFS_SYS_CTRL, 32'ha0);
    xfer(1'b1, OFS_POLARITY, 32'h1);
    pins_chk(3'b010);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    pins_chk(3'b100);
    rd_chk(OFS_POLARITY, 32'h0);
    finish_test();
  end
endmodule : usb_device_event_interrupts_tb
